/* File: design/ssq_pkg.sv */
// constants, opcodes and state codes of the serial eeprom command sequencer
package ssq_pkg;
	// array geometry
	localparam int ADDR_W = 11;
	localparam int PAGE_W = 5;
	localparam int PAGE_BYTES = 32;
	localparam int CMD_BITS = 8;
	localparam int ADDR_BITS = 16;

	// opcodes, sent msb first
	localparam logic [7:0] OP_SET_LATCH = 8'h06;
	localparam logic [7:0] OP_CLR_LATCH = 8'h04;
	localparam logic [7:0] OP_STAT_RD = 8'h05;
	localparam logic [7:0] OP_STAT_WR = 8'h01;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_WRITE = 8'h02;

	// status byte field positions
	localparam int ST_BUSY_BIT = 0;
	localparam int ST_LATCH_BIT = 1;
	localparam int ST_PROT_LO_BIT = 2;
	localparam int ST_PROT_HI_BIT = 3;
	localparam int ST_GUARD_BIT = 7;
	localparam logic [7:0] ST_BUSY_VALUE = 8'hff;

	// protection level codes
	localparam logic [1:0] PROT_NONE = 2'h0;
	localparam logic [1:0] PROT_QUARTER = 2'h1;
	localparam logic [1:0] PROT_HALF = 2'h2;
	localparam logic [1:0] PROT_ALL = 2'h3;

	// values after reset
	localparam logic [1:0] PROT_RESET = 2'h0;
	localparam logic GUARD_RESET = 1'b0;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [10:0] ADDR_RESET = 11'h000;

	// timing: write cycle is a longest time, so it rounds down
	localparam longint CLK_PERIOD_PS = 50000;
	localparam longint T_WRITE_MS = 10;
	localparam int WRITE_CYCLES = int'((T_WRITE_MS * 64'd1000000000) / CLK_PERIOD_PS);

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_OPC = 4'h1,
		ST_ADDR = 4'h2,
		ST_RDATA = 4'h3,
		ST_RSTAT = 4'h4,
		ST_WDATA = 4'h5,
		ST_WSTAT = 4'h6,
		ST_LATCH = 4'h7,
		ST_IGNORE = 4'h8
	} ssq_state_t;
endpackage

/* File: design/ssq_seq.sv */
// spi serial eeprom command sequencer, device side
// Functional notes
// - sample input on rise, drive output on fall
// - read is opcode, 16-bit address, low 11 used
// - read streams bytes, address advancing each byte
// - read address wraps from top to zero
// - chip select high ends any read
// - status read opcode streams status byte out
// - latch set only if frame ends after eight
// - write address wraps inside its page
// - write starts only at a byte boundary
// - status reads answer busy during write cycle
// - pause input freezes transfer, resumes in place
// - reset: standby, output off, latch clear
// - opcodes as listed, msb first
// - write latch clears when write cycle completes
// - protect level bars quarter, half, or all
// - status layout busy, latch, protect, guard
module ssq_seq #(
	parameter int WC_CYCLES = ssq_pkg::WRITE_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	input wire logic cs_n_i,
	input wire logic sck_i,
	input wire logic si_i,
	input wire logic hold_n_i,
	input wire logic wp_n_i,
	output logic so_o,
	output logic so_oe_n_o,
	output logic write_busy_o
);
	import ssq_pkg::*;

	localparam int NPIN = 5;

	logic [NPIN-1:0] pin_meta_reg;
	logic [NPIN-1:0] pin_sync_reg;
	logic cs_d_reg;
	logic sck_d_reg;
	logic cs_s, sck_s, si_s, hold_s, wp_s;
	logic cs_fall, cs_rise, sck_rise, sck_fall, run;
	ssq_state_t state_reg;
	logic [3:0] bit_cnt_reg;
	logic [7:0] in_sh_reg;
	logic [7:0] out_sh_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [ADDR_W-1:0] addr_next;
	logic [ADDR_W-1:0] addr_inc;
	logic [7:0] op_next;
	logic byte_ok_reg;
	logic latch_val_reg;
	logic drv_reg;
	logic so_reg;
	logic oe_n_reg;
	logic busy_reg;
	logic write_latch_flag;
	logic [1:0] prot_reg;
	logic guard_pin_enable;
	logic [7:0] stat_data_reg;
	logic [7:0] stat_byte;
	logic [7:0] mem [0:(1 << ADDR_W)-1];
	logic [7:0] page_buf [0:PAGE_BYTES-1];
	logic [PAGE_BYTES-1:0] page_mask_reg;
	logic [ADDR_W-PAGE_W-1:0] page_reg;
	logic [PAGE_W:0] cidx_reg;
	logic kind_stat_reg;
	logic start_reg;
	logic page_prot;
	logic arr_go, stat_go;

	ssq_wc_if wc ();

	ssq_wtimer #(
		.CYCLES(WC_CYCLES)
	) u_wtimer (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.ce_i(ce_i),
		.wc(wc)
	);

	// every pin passes two flops; only the second stage is read
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			pin_meta_reg <= '0;
			pin_sync_reg <= '0;
			cs_d_reg <= 1'b0;
			sck_d_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			pin_meta_reg <= {wp_n_i, hold_n_i, si_i, sck_i, cs_n_i};
			pin_sync_reg <= pin_meta_reg;
			cs_d_reg <= pin_sync_reg[0];
			sck_d_reg <= pin_sync_reg[1];
		end
	end

	// cs history resets low, so a select held low through reset is no fall
	assign cs_s = pin_sync_reg[0];
	assign sck_s = pin_sync_reg[1];
	assign si_s = pin_sync_reg[2];
	assign hold_s = pin_sync_reg[3];
	assign wp_s = pin_sync_reg[4];
	assign cs_fall = cs_d_reg && !cs_s;
	assign cs_rise = !cs_d_reg && cs_s;
	assign sck_rise = !sck_d_reg && sck_s;
	assign sck_fall = sck_d_reg && !sck_s;
	assign run = !cs_s && hold_s && state_reg != ST_IDLE;

	// status byte; while busy every bit reads one
	assign stat_byte = busy_reg ? ST_BUSY_VALUE :
		{guard_pin_enable, 3'h0, prot_reg, write_latch_flag, 1'b0};
	assign addr_next = {addr_reg[ADDR_W-2:0], si_s};
	assign addr_inc = addr_reg + 11'h001;
	assign op_next = {in_sh_reg[6:0], si_s};

	// command sequencer: opcode, address, data phases
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			state_reg <= ST_IDLE;
			bit_cnt_reg <= 4'h0;
			in_sh_reg <= BYTE_RESET;
			out_sh_reg <= BYTE_RESET;
			addr_reg <= ADDR_RESET;
			byte_ok_reg <= 1'b0;
			latch_val_reg <= 1'b0;
			drv_reg <= 1'b0;
			so_reg <= 1'b0;
			stat_data_reg <= BYTE_RESET;
			page_mask_reg <= '0;
		end
		else if (ce_i)
		begin
			if (cs_s)
			begin
				state_reg <= ST_IDLE;
				drv_reg <= 1'b0;
			end
			else if (cs_fall)
			begin
				state_reg <= ST_OPC;
				bit_cnt_reg <= 4'h0;
				byte_ok_reg <= 1'b0;
				drv_reg <= 1'b0;
			end
			else if (run && sck_rise)
			begin
				in_sh_reg <= op_next;
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				case (state_reg)
					ST_OPC:
					begin
						if (bit_cnt_reg == 4'(CMD_BITS - 1))
						begin
							bit_cnt_reg <= 4'h0;
							if (busy_reg && op_next != OP_STAT_RD)
								state_reg <= ST_IGNORE;
							else
							begin
								case (op_next)
									OP_STAT_RD:
									begin
										state_reg <= ST_RSTAT;
										out_sh_reg <= stat_byte;
									end
									OP_READ:
									begin
										state_reg <= ST_ADDR;
										latch_val_reg <= 1'b0;
									end
									OP_WRITE:
									begin
										state_reg <= ST_ADDR;
										latch_val_reg <= 1'b1;
										page_mask_reg <= '0;
									end
									OP_STAT_WR:
										state_reg <= ST_WSTAT;
									OP_SET_LATCH:
									begin
										state_reg <= ST_LATCH;
										latch_val_reg <= 1'b1;
									end
									OP_CLR_LATCH:
									begin
										state_reg <= ST_LATCH;
										latch_val_reg <= 1'b0;
									end
									default:
										state_reg <= ST_IGNORE;
								endcase
							end
						end
					end
					ST_ADDR:
					begin
						addr_reg <= addr_next;
						if (bit_cnt_reg == 4'(ADDR_BITS - 1))
						begin
							bit_cnt_reg <= 4'h0;
							if (latch_val_reg)
								state_reg <= ST_WDATA;
							else
							begin
								state_reg <= ST_RDATA;
								out_sh_reg <= mem[addr_next];
							end
						end
					end
					ST_RDATA:
					begin
						if (bit_cnt_reg == 4'(CMD_BITS - 1))
						begin
							bit_cnt_reg <= 4'h0;
							addr_reg <= addr_inc;
							out_sh_reg <= mem[addr_inc];
						end
					end
					ST_RSTAT:
					begin
						if (bit_cnt_reg == 4'(CMD_BITS - 1))
						begin
							bit_cnt_reg <= 4'h0;
							out_sh_reg <= stat_byte;
						end
					end
					ST_WDATA:
					begin
						if (bit_cnt_reg == 4'(CMD_BITS - 1))
						begin
							bit_cnt_reg <= 4'h0;
							byte_ok_reg <= 1'b1;
							page_mask_reg[addr_reg[PAGE_W-1:0]] <= 1'b1;
							addr_reg <= {addr_reg[ADDR_W-1:PAGE_W],
								addr_reg[PAGE_W-1:0] + 5'h01};
						end
					end
					ST_WSTAT:
					begin
						// a ninth status bit spoils the frame
						if (byte_ok_reg)
							state_reg <= ST_IGNORE;
						else if (bit_cnt_reg == 4'(CMD_BITS - 1))
						begin
							bit_cnt_reg <= 4'h0;
							byte_ok_reg <= 1'b1;
							stat_data_reg <= op_next;
						end
					end
					ST_LATCH:
						state_reg <= ST_IGNORE;
					default:
						state_reg <= ST_IGNORE;
				endcase
			end
			else if (run && sck_fall && (state_reg == ST_RDATA || state_reg == ST_RSTAT))
			begin
				so_reg <= out_sh_reg[7];
				out_sh_reg <= {out_sh_reg[6:0], 1'b0};
				drv_reg <= 1'b1;
			end
		end
	end

	// page loads land in a buffer; the array is touched only once the cycle starts
	always_ff @(posedge core_clk_i)
	begin
		if (ce_i && run && sck_rise && state_reg == ST_WDATA
			&& bit_cnt_reg == 4'(CMD_BITS - 1))
			page_buf[addr_reg[PAGE_W-1:0]] <= op_next;
	end

	// output off while deselected or paused; driving resumes as it was
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			oe_n_reg <= 1'b1;
		else if (ce_i)
			oe_n_reg <= !(!cs_s && hold_s && drv_reg);
	end

	assign page_prot = (prot_reg == PROT_ALL)
		|| (prot_reg == PROT_HALF && addr_reg[ADDR_W-1])
		|| (prot_reg == PROT_QUARTER && addr_reg[ADDR_W-1:ADDR_W-2] == 2'h3);
	assign arr_go = cs_rise && state_reg == ST_WDATA && bit_cnt_reg == 4'h0
		&& byte_ok_reg && write_latch_flag && !page_prot;
	assign stat_go = cs_rise && state_reg == ST_WSTAT && byte_ok_reg
		&& write_latch_flag && !(guard_pin_enable && !wp_s);

	// write latch and start of the self-timed cycle at deselect
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			write_latch_flag <= 1'b0;
			start_reg <= 1'b0;
			kind_stat_reg <= 1'b0;
			page_reg <= '0;
		end
		else if (ce_i)
		begin
			start_reg <= arr_go || stat_go;
			if (arr_go || stat_go)
			begin
				kind_stat_reg <= stat_go;
				page_reg <= addr_reg[ADDR_W-1:PAGE_W];
			end
			if (wc.done)
				write_latch_flag <= 1'b0;
			else if (cs_rise && state_reg == ST_LATCH)
				write_latch_flag <= latch_val_reg;
		end
	end

	assign wc.start = start_reg;

	// array commit walks the page mask, one byte a cycle, at cycle start
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cidx_reg <= 6'h20;
			busy_reg <= 1'b0;
			prot_reg <= PROT_RESET;
			guard_pin_enable <= GUARD_RESET;
		end
		else if (ce_i)
		begin
			busy_reg <= wc.busy || start_reg;
			if (start_reg)
				cidx_reg <= kind_stat_reg ? 6'h20 : 6'h00;
			else if (!cidx_reg[PAGE_W])
				cidx_reg <= cidx_reg + 6'h01;
			if (wc.done && kind_stat_reg)
			begin
				prot_reg <= {stat_data_reg[ST_PROT_HI_BIT], stat_data_reg[ST_PROT_LO_BIT]};
				guard_pin_enable <= stat_data_reg[ST_GUARD_BIT];
			end
		end
	end

	// the array itself has no reset: contents are not control state
	always_ff @(posedge core_clk_i)
	begin
		if (ce_i && !cidx_reg[PAGE_W] && page_mask_reg[cidx_reg[PAGE_W-1:0]])
			mem[{page_reg, cidx_reg[PAGE_W-1:0]}] <= page_buf[cidx_reg[PAGE_W-1:0]];
	end

	assign so_o = so_reg;
	assign so_oe_n_o = oe_n_reg;
	assign write_busy_o = busy_reg;

	a_rise_capture: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && run && sck_rise && !cs_fall) |=> in_sh_reg[0] == $past(si_s))
		else $error("input bit not captured on clock rise");
	a_fall_drive: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && run && sck_fall && state_reg == ST_RDATA) |=> so_reg == $past(out_sh_reg[7]))
		else $error("output bit not driven on clock fall");
	a_read_advance: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && run && sck_rise && state_reg == ST_RDATA && bit_cnt_reg == 4'h7)
		|=> addr_reg == $past(addr_reg) + 11'h001)
		else $error("read address did not advance after a byte");
	a_page_stays: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && run && sck_rise && state_reg == ST_WDATA)
		|=> addr_reg[ADDR_W-1:PAGE_W] == $past(addr_reg[ADDR_W-1:PAGE_W]))
		else $error("write address left its page");
	a_deselect_quiet: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && cs_s) |=> (state_reg == ST_IDLE && oe_n_reg))
		else $error("deselect did not stop the transfer");
	a_busy_refuse: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && run && sck_rise && state_reg == ST_OPC && bit_cnt_reg == 4'h7
		&& busy_reg && op_next != OP_STAT_RD) |=> state_reg == ST_IGNORE)
		else $error("command accepted during write cycle");
	a_latch_clear: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && wc.done) |=> !write_latch_flag)
		else $error("write latch survived the write cycle");
	a_pause_freeze: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && !cs_s && !cs_fall && !hold_s) |=> ($stable(state_reg) && $stable(bit_cnt_reg)))
		else $error("sequencer moved while paused");
	a_start_edge: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && start_reg) |-> $past(cs_rise && byte_ok_reg && bit_cnt_reg == 4'h0))
		else $error("write cycle started off a byte boundary");
	a_busy_status: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && run && sck_rise && state_reg == ST_OPC && bit_cnt_reg == 4'h7
		&& busy_reg && op_next == OP_STAT_RD) |=> out_sh_reg == ST_BUSY_VALUE)
		else $error("status does not show busy");
endmodule

/* File: design/ssq_wc_if.sv */
// handshake between the command sequencer and its write cycle timer
interface ssq_wc_if;
	logic start;
	logic busy;
	logic done;
	modport ctl (output start, input busy, input done);
	modport tmr (input start, output busy, output done);
endinterface

/* File: design/ssq_wtimer.sv */
// self-timed internal write cycle timer
module ssq_wtimer #(
	parameter int CYCLES = ssq_pkg::WRITE_CYCLES
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic ce_i,
	ssq_wc_if.tmr wc
);
	import ssq_pkg::*;

	localparam int CW = $clog2(CYCLES + 1);
	localparam logic [CW-1:0] CNT_LAST = CW'(CYCLES - 1);

	logic [CW-1:0] cnt_reg;
	logic busy_reg;
	logic done_reg;

	// a start while already busy is dropped; the sequencer never asks for one
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			cnt_reg <= '0;
			busy_reg <= 1'b0;
			done_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			done_reg <= 1'b0;
			if (!busy_reg && wc.start)
			begin
				busy_reg <= 1'b1;
				cnt_reg <= '0;
			end
			else if (busy_reg)
			begin
				if (cnt_reg == CNT_LAST)
				begin
					busy_reg <= 1'b0;
					done_reg <= 1'b1;
				end
				cnt_reg <= cnt_reg + CW'(1);
			end
		end
	end

	assign wc.busy = busy_reg;
	assign wc.done = done_reg;

	a_busy_span: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
		(ce_i && !busy_reg && wc.start) |=> busy_reg)
		else $error("write timer did not go busy on start");
endmodule

/* File: tb/ssq_host_model.sv */
// host spi master model, mode 0, that drives the sequencer pins
module ssq_host_model (
	output logic cs_n_o,
	output logic sck_o,
	output logic si_o,
	output logic hold_n_o,
	input wire logic so_i,
	input wire logic so_oe_n_i
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HALF_NS = 200;

	// idle bus: deselected, clock parked low, no pause
	initial
	begin
		cs_n_o = 1'b1;
		sck_o = 1'b0;
		si_o = 1'b1;
		hold_n_o = 1'b1;
	end

	// data set while the clock is low, taken by the device on the rise
	task automatic bit_xfer(input logic tx, output logic rx);
	begin
		si_o = tx;
		#(HALF_NS);
		sck_o = 1'b1;
		// the device has taken the bit long before mid-high, so stop showing it
		#(HALF_NS / 2);
		si_o = ~tx;
		#(HALF_NS / 2 - 10);
		rx = so_oe_n_i ? 1'bx : so_i; // a released output never reads as data
		#10;
		sck_o = 1'b0;
	end
	endtask

	// whole bytes, most significant bit first
	task automatic byte_xfer(input logic [7:0] tx, output logic [7:0] rx);
		logic b;
	begin
		for (int i = 7; i >= 0; i--)
		begin
			bit_xfer(tx[i], b);
			rx[i] = b;
		end
	end
	endtask

	task automatic select();
	begin
		cs_n_o = 1'b0;
		#(HALF_NS);
	end
	endtask

	// raising select ends any read and starts a pending write
	task automatic deselect();
	begin
		#(HALF_NS);
		cs_n_o = 1'b1;
		#(HALF_NS * 3);
	end
	endtask

	// pause with junk clocks that the device must not see
	task automatic pause();
	begin
		hold_n_o = 1'b0;
		#(HALF_NS);
		repeat (3)
		begin
			si_o = ~si_o;
			#(HALF_NS);
			sck_o = 1'b1;
			#(HALF_NS);
			sck_o = 1'b0;
		end
		#(HALF_NS);
		hold_n_o = 1'b1;
		#(HALF_NS);
	end
	endtask
endmodule

/* File: tb/tb_spi_eeprom_command_sequencer.sv */
// self-checking bench for the serial eeprom command sequencer
module tb_spi_eeprom_command_sequencer import ssq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// short write cycle keeps the run brief but outlasts a status frame
	localparam int WC = 1024;
	logic core_clk_i;
	logic nrst_i;
	logic wp_n;
	int n_drive = 0;
	int d0;
	wire cs_n;
	wire sck;
	wire si;
	wire hold_n;
	wire so;
	wire so_oe_n;
	wire busy;
	int n_mismatch;
	int n_checks;
	logic [7:0] rdq[$];
	logic [15:0] addrs [3] = '{16'h0100, 16'h0500, 16'h0600};
	logic [15:0] lim [4] = '{16'h0800, 16'h0600, 16'h0400, 16'h0000};

	ssq_seq #(.WC_CYCLES(WC)) u_dut (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.ce_i(1'b1),
		.cs_n_i(cs_n),
		.sck_i(sck),
		.si_i(si),
		.hold_n_i(hold_n),
		.wp_n_i(wp_n),
		.so_o(so),
		.so_oe_n_o(so_oe_n),
		.write_busy_o(busy)
	);

	ssq_host_model u_host (
		.cs_n_o(cs_n),
		.sck_o(sck),
		.si_o(si),
		.hold_n_o(hold_n),
		.so_i(so),
		.so_oe_n_i(so_oe_n)
	);

	always #25 core_clk_i = ~core_clk_i;

	// counts cycles in which the output is driven; one process owns the count
	always @(posedge core_clk_i)
		if (so_oe_n === 1'b0)
			n_drive <= n_drive + 1;

	task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
	begin
		n_checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	end
	endtask

	task automatic report_and_stop();
	begin
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	end
	endtask

	// one frame: bytes out, stray bits, then bytes read; pz pauses after that byte
	task automatic frame(input logic [7:0] txq[$], input int extra, input int nrd, input int pz);
		logic [7:0] r;
		logic b;
	begin
		@(posedge core_clk_i);
		#1;
		rdq = {};
		u_host.select();
		foreach (txq[i])
		begin
			u_host.byte_xfer(txq[i], r);
			if (i == pz)
				u_host.pause();
		end
		repeat (extra)
			u_host.bit_xfer(1'b0, b);
		repeat (nrd)
		begin
			u_host.byte_xfer(8'h00, r);
			rdq.push_back(r);
		end
		u_host.deselect();
	end
	endtask

	// checks whether a write cycle began, then waits a bounded time for its end
	task automatic busy_cycle(input logic exp, input string what);
		int n;
	begin
		check(what, {7'h0, exp}, {7'h0, busy});
		if (busy === 1'b1)
		begin
			frame({OP_STAT_RD}, 0, 1, -1);
			check("status while busy", ST_BUSY_VALUE, rdq[0]);
		end
		n = 0;
		while (busy !== 1'b0 && n < WC + 40)
		begin
			@(posedge core_clk_i);
			n++;
		end
		if (busy !== 1'b0)
		begin
			check("busy wait", 8'h00, {7'h0, busy});
			report_and_stop();
		end
	end
	endtask

	initial
	begin
		core_clk_i = 1'b0;
		nrst_i = 1'b0;
		wp_n = 1'b1;
		n_mismatch = 0;
		n_checks = 0;
		repeat (4) @(posedge core_clk_i);
		#1;
		nrst_i = 1'b1;
		check("oe after reset", 8'h01, {7'h0, so_oe_n});
		check("busy after reset", 8'h00, {7'h0, busy});
		repeat (4) @(posedge core_clk_i);
		frame({OP_STAT_RD}, 0, 2, -1);
		check("status at start", 8'h00, rdq[0]);
		check("status repeated", 8'h00, rdq[1]);
		frame({OP_SET_LATCH}, 8, 0, -1);
		frame({OP_STAT_RD}, 0, 1, -1);
		check("latch after long frame", 8'h00, rdq[0]);
		frame({OP_SET_LATCH}, 0, 0, -1);
		frame({OP_STAT_RD}, 0, 1, -1);
		check("latch set", 8'h02, rdq[0]);
		frame({OP_CLR_LATCH}, 0, 0, -1);
		frame({OP_STAT_RD}, 0, 1, -1);
		check("latch cleared", 8'h00, rdq[0]);
		frame({OP_WRITE, 8'h00, 8'h00, 8'h99}, 0, 0, -1);
		busy_cycle(1'b0, "write without latch");
		// top address bits set; third byte wraps to the page start
		frame({OP_SET_LATCH}, 0, 0, -1);
		frame({OP_WRITE, 8'hff, 8'hfe, 8'h11, 8'h22, 8'h33}, 0, 0, -1);
		d0 = n_drive;
		frame({OP_READ, 8'h07, 8'hfe}, 0, 1, -1);
		check("read while busy drove", 8'h00, {7'h0, n_drive != d0});
		busy_cycle(1'b1, "page write");
		frame({OP_SET_LATCH}, 0, 0, -1);
		frame({OP_WRITE, 8'h00, 8'h00, 8'h44}, 0, 0, -1);
		busy_cycle(1'b1, "byte write");
		frame({OP_STAT_RD}, 0, 1, -1);
		check("latch after write", 8'h00, rdq[0]);
		frame({OP_SET_LATCH}, 0, 0, -1);
		frame({OP_WRITE, 8'h00, 8'h00, 8'h99}, 3, 0, -1);
		busy_cycle(1'b0, "write off byte boundary");
		frame({OP_CLR_LATCH}, 0, 0, -1);
		frame({OP_READ, 8'h07, 8'hfe}, 0, 3, -1);
		check("read 7fe", 8'h11, rdq[0]);
		check("read 7ff", 8'h22, rdq[1]);
		check("read wraps to 000", 8'h44, rdq[2]);
		frame({OP_READ, 8'h07, 8'he0}, 0, 1, 1);
		check("paused read of page start", 8'h33, rdq[0]);
		d0 = n_drive;
		frame({8'hff}, 16, 1, -1);
		check("unknown opcode drove", 8'h00, {7'h0, n_drive != d0});
		// every protect level against three addresses
		for (int p = 0; p < 4; p++)
		begin
			frame({OP_SET_LATCH}, 0, 0, -1);
			frame({OP_STAT_WR, 8'(p << 2)}, 0, 0, -1);
			busy_cycle(1'b1, "status write");
			frame({OP_STAT_RD}, 0, 1, -1);
			check("protect level", 8'(p << 2), rdq[0]);
			foreach (addrs[k])
			begin
				frame({OP_SET_LATCH}, 0, 0, -1);
				frame({OP_WRITE, addrs[k][15:8], addrs[k][7:0], 8'h5a}, 0, 0, -1);
				busy_cycle(addrs[k] < lim[p], "protected write");
				frame({OP_CLR_LATCH}, 0, 0, -1);
			end
		end
		// guard enable set, then pin low bars status writes
		frame({OP_SET_LATCH}, 0, 0, -1);
		frame({OP_STAT_WR, 8'h80}, 0, 0, -1);
		busy_cycle(1'b1, "guard enable write");
		@(posedge core_clk_i);
		#1;
		wp_n = 1'b0;
		frame({OP_SET_LATCH}, 0, 0, -1);
		frame({OP_STAT_WR, 8'h00}, 0, 0, -1);
		busy_cycle(1'b0, "guarded status write");
		frame({OP_STAT_RD}, 0, 1, -1);
		check("status guarded", 8'h82, rdq[0]);
		report_and_stop();
	end
endmodule
